// ---- hdl/sfwp_pkg.sv ----
// Shared constants for the serial flash write-protection block.
// Assumes a single-bit serial link sampled by a faster system clock.
package sfwp_pkg;
   // ==========================================================
   // Command opcodes.
   localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
   localparam logic [7:0] CMD_WRITE_STATUS   = 8'h01;
   localparam logic [7:0] CMD_PAGE_PROG      = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h20;
   localparam logic [7:0] CMD_BLOCK32_ERASE  = 8'h52;
   localparam logic [7:0] CMD_BLOCK64_ERASE  = 8'hD8;
   localparam logic [7:0] CMD_CHIP_ERASE     = 8'hC7;
   localparam logic [7:0] CMD_POWER_DOWN     = 8'hB9;
   localparam logic [7:0] CMD_RELEASE_PD     = 8'hAB;
   localparam logic [7:0] CMD_ENTER_SECURE   = 8'hB1;
   localparam logic [7:0] CMD_EXIT_SECURE    = 8'hC1;
   localparam logic [7:0] CMD_WRITE_SECURITY = 8'h2F;
   localparam logic [7:0] CMD_SUSPEND        = 8'hB0;
   localparam logic [7:0] CMD_RESUME         = 8'h30;
   localparam logic [7:0] CMD_RESET_ENABLE   = 8'h66;
   localparam logic [7:0] CMD_RESET          = 8'h99;
   localparam logic [7:0] CMD_QUAD_ENTER     = 8'h35;
   localparam logic [7:0] CMD_QUAD_EXIT      = 8'hF5;
   localparam logic [7:0] CMD_BLOCK_LOCK     = 8'h36;
   localparam logic [7:0] CMD_BLOCK_UNLOCK   = 8'h39;
   localparam logic [7:0] CMD_GANG_LOCK      = 8'h7E;
   localparam logic [7:0] CMD_GANG_UNLOCK    = 8'h98;
   // ==========================================================
   // Command lengths in whole bytes.
   localparam logic [2:0] LEN_SHORT    = 3'h1;
   localparam logic [2:0] LEN_STATUS   = 3'h2;
   localparam logic [2:0] LEN_ADDR     = 3'h5;
   localparam logic [2:0] LEN_PROG_MIN = 3'h6;
   // ==========================================================
   // Status and security bit positions, values after reset.
   localparam int SR_WEL_BIT   = 1;
   localparam int SR_LEVEL_LSB = 2;
   localparam int SR_QE_BIT    = 6;
   localparam int SR_SRWD_BIT  = 7;
   localparam int SEC_FACT_BIT = 0;
   localparam int SEC_CUST_BIT = 1;
   localparam int OTP_HALF_BIT = 9;
   localparam logic [1:0] STRAP_CATCH = 2'h2;
   // ==========================================================
   // Array geometry: 64 KB blocks, all-protect level.
   localparam logic [10:0] BLOCK_COUNT = 11'h400;
   localparam logic [3:0]  LEVEL_ALL   = 4'hB;
   // Kind of internal write cycle started.
   typedef enum logic [2:0] {
      OP_NONE     = 3'b000,
      OP_PROG     = 3'b001,
      OP_SECTOR   = 3'b010,
      OP_BLK32    = 3'b011,
      OP_BLK64    = 3'b100,
      OP_CHIP     = 3'b101,
      OP_STATUS   = 3'b110,
      OP_SECURITY = 3'b111
   } sfwp_op_t;
endpackage

// ---- hdl/sfwp_top.sv ----
// Command framing and write protection of a serial NOR flash.
// Assumes cs_n, sclk, si and the protect pin arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module sfwp_top (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        si,
   input  wire logic        write_protect_pin_io2,
   input  wire logic        factory_lock_strap,
   input  wire logic        top_bottom_sel,
   output logic [7:0]       status_reg,
   output logic [1:0]       security_reg,
   output logic             power_down,
   output logic             secured_mode,
   output logic             quad_mode,
   output logic             op_start,
   output sfwp_pkg::sfwp_op_t op_kind,
   output logic [25:0]      op_addr,
   output logic             op_otp,
   output logic             cmd_reject
);
   // ==========================================================
   // State record: stage [0] of each synchroniser is first flop.
   typedef struct packed {
      logic [1:0]         cs_sy;
      logic [1:0]         sclk_sy;
      logic [1:0]         si_sy;
      logic [1:0]         wp_sy;
      logic [1:0]         strap_sy;
      logic [1:0]         strap_cnt;
      logic               sclk_last;
      logic               cs_last;
      logic [6:0]         shift;
      logic [2:0]         bits;
      logic [2:0]         bytes;
      logic [7:0]         opcode;
      logic [31:0]        addr;
      logic [7:0]         data;
      logic [7:0]         status;
      logic [1:0]         security;
      logic               power_down;
      logic               secured;
      logic               quad;
      logic               reset_armed;
      logic [1023:0]      blk_lock;
      logic [31:0]        sec_lock;
      logic               op_start;
      sfwp_pkg::sfwp_op_t op_kind;
      logic [25:0]        op_addr;
      logic               op_otp;
      logic               reject;
   } sfwp_state_t;
   sfwp_state_t s_q;
   sfwp_state_t s_d;
   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_rise;
   logic [3:0]  level;
   // ==========================================================
   // Decoders.
   // Expected length of a command; zero marks an unknown opcode.
   function automatic logic [2:0] sfwp_cmd_len(input logic [7:0] op);
      unique case (op)
         sfwp_pkg::CMD_WRITE_STATUS:  return sfwp_pkg::LEN_STATUS;
         sfwp_pkg::CMD_PAGE_PROG:     return sfwp_pkg::LEN_PROG_MIN;
         sfwp_pkg::CMD_SECTOR_ERASE, sfwp_pkg::CMD_BLOCK32_ERASE,
         sfwp_pkg::CMD_BLOCK64_ERASE, sfwp_pkg::CMD_BLOCK_LOCK,
         sfwp_pkg::CMD_BLOCK_UNLOCK:  return sfwp_pkg::LEN_ADDR;
         sfwp_pkg::CMD_WRITE_ENABLE, sfwp_pkg::CMD_WRITE_DISABLE,
         sfwp_pkg::CMD_CHIP_ERASE, sfwp_pkg::CMD_POWER_DOWN,
         sfwp_pkg::CMD_RELEASE_PD, sfwp_pkg::CMD_ENTER_SECURE,
         sfwp_pkg::CMD_EXIT_SECURE, sfwp_pkg::CMD_WRITE_SECURITY,
         sfwp_pkg::CMD_SUSPEND, sfwp_pkg::CMD_RESUME,
         sfwp_pkg::CMD_RESET_ENABLE, sfwp_pkg::CMD_RESET,
         sfwp_pkg::CMD_QUAD_ENTER, sfwp_pkg::CMD_QUAD_EXIT,
         sfwp_pkg::CMD_GANG_LOCK, sfwp_pkg::CMD_GANG_UNLOCK:
                                      return sfwp_pkg::LEN_SHORT;
         default:                     return 3'h0;
      endcase
   endfunction
   // Commands still heard in deep power-down.
   function automatic logic sfwp_pd_pass(input logic [7:0] op);
      return (op == sfwp_pkg::CMD_RELEASE_PD) || (op == sfwp_pkg::CMD_SUSPEND) ||
             (op == sfwp_pkg::CMD_RESUME) || (op == sfwp_pkg::CMD_RESET_ENABLE) ||
             (op == sfwp_pkg::CMD_RESET);
   endfunction
   // Level-coded region hit for one 64 KB block.
   function automatic logic sfwp_level_hit(input logic [9:0] blk, input logic [3:0] lvl,
                                           input logic tb);
      logic [10:0] n;
      n = 11'h001 << (lvl - 4'h1);
      if (lvl == 4'h0) return 1'b0;
      if (lvl >= sfwp_pkg::LEVEL_ALL) return 1'b1;
      if (tb) return {1'b0, blk} < n;
      return {1'b0, blk} >= (sfwp_pkg::BLOCK_COUNT - n);
   endfunction
   // Lock-bit hit; the edge blocks use their sixteen sector bits.
   function automatic logic sfwp_lock_hit(input logic [25:0] a, input sfwp_pkg::sfwp_op_t k,
                                          input logic [1023:0] bl, input logic [31:0] sl);
      logic [9:0] blk;
      blk = a[25:16];
      if (blk != 10'h000 && blk != 10'h3FF) return bl[blk];
      if (k == sfwp_pkg::OP_BLK64) return |sl[{blk[9], 4'h0} +: 16];
      if (k == sfwp_pkg::OP_BLK32) return |sl[{blk[9], a[15], 3'h0} +: 8];
      return sl[{blk[9], a[15:12]}];
   endfunction

   // ==========================================================
   // Link edge detection, read only from second sync stages.
   assign cs_fall   = s_q.cs_last & ~s_q.cs_sy[1];
   assign cs_rise   = ~s_q.cs_last & s_q.cs_sy[1];
   assign sclk_rise = ~s_q.sclk_last & s_q.sclk_sy[1] & ~s_q.cs_sy[1];
   assign level     = s_q.status[sfwp_pkg::SR_LEVEL_LSB +: 4];

   // ==========================================================
   // Next-state logic: shifting, then command checks at chip-select rise.
   always_comb begin
      logic        frame_ok;
      logic        write_enable_latch;
      logic        hw_lock;
      logic [2:0]  want;
      logic [7:0]  byte_in;
      logic [25:0] a;
      sfwp_pkg::sfwp_op_t k;
      s_d          = s_q;
      frame_ok     = 1'b0;
      write_enable_latch          = s_q.status[sfwp_pkg::SR_WEL_BIT];
      want         = sfwp_cmd_len(s_q.opcode);
      byte_in      = {s_q.shift, s_q.si_sy[1]};
      a            = s_q.addr[25:0];
      k            = sfwp_pkg::OP_NONE;
      hw_lock      = s_q.status[sfwp_pkg::SR_SRWD_BIT] & ~s_q.wp_sy[1] &
                     ~(s_q.quad | s_q.status[sfwp_pkg::SR_QE_BIT]);
      s_d.op_start = 1'b0;
      s_d.reject   = 1'b0;
      s_d.cs_sy    = {s_q.cs_sy[0], cs_n};
      s_d.sclk_sy  = {s_q.sclk_sy[0], sclk};
      s_d.si_sy    = {s_q.si_sy[0], si};
      s_d.wp_sy    = {s_q.wp_sy[0], write_protect_pin_io2};
      s_d.strap_sy = {s_q.strap_sy[0], factory_lock_strap};
      s_d.sclk_last = s_q.sclk_sy[1];
      s_d.cs_last   = s_q.cs_sy[1];
      // Factory lock strap is caught once its synchroniser has filled.
      if (s_q.strap_cnt != 2'h3) begin
         s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
      if (s_q.strap_cnt == sfwp_pkg::STRAP_CATCH) begin
         s_d.security[sfwp_pkg::SEC_FACT_BIT] = s_q.security[0] | s_q.strap_sy[1];
      end
      if (cs_fall) begin
         s_d.bits  = 3'h0;
         s_d.bytes = 3'h0;
      end else if (sclk_rise) begin
         s_d.shift = byte_in[6:0];
         s_d.bits  = s_q.bits + 3'h1;
         if (s_q.bits == 3'h7) begin
            if (s_q.bytes != 3'h7) begin
               s_d.bytes = s_q.bytes + 3'h1;
            end
            if (s_q.bytes == 3'h0) begin
               s_d.opcode = byte_in;
            end else if (s_q.bytes <= 3'h4) begin
               s_d.addr = {s_q.addr[23:0], byte_in};
            end else if (s_q.bytes == 3'h5) begin
               s_d.data = byte_in;
            end
         end
      end else if (cs_rise && (s_q.bytes != 3'h0 || s_q.bits != 3'h0)) begin
         // A frame with any bit at all is judged; a partial byte is refused.
         // Whole bytes, exact length (at least the minimum for page program), and the power-down filter.
         frame_ok = (s_q.bits == 3'h0) && (want != 3'h0) &&
                    ((s_q.opcode == sfwp_pkg::CMD_PAGE_PROG) ? (s_q.bytes >= want)
                                                            : (s_q.bytes == want)) &&
                    (!s_q.power_down || sfwp_pd_pass(s_q.opcode));
         s_d.reject = 1'b1;
         if (frame_ok) begin
            s_d.reject      = 1'b0;
            s_d.reset_armed = 1'b0;
            unique case (s_q.opcode)
               sfwp_pkg::CMD_WRITE_ENABLE:  s_d.status[sfwp_pkg::SR_WEL_BIT] = 1'b1;
               sfwp_pkg::CMD_WRITE_DISABLE: s_d.status[sfwp_pkg::SR_WEL_BIT] = 1'b0;
               sfwp_pkg::CMD_POWER_DOWN:    s_d.power_down = 1'b1;
               sfwp_pkg::CMD_RELEASE_PD:    s_d.power_down = 1'b0;
               sfwp_pkg::CMD_ENTER_SECURE:  s_d.secured = 1'b1;
               sfwp_pkg::CMD_EXIT_SECURE:   s_d.secured = 1'b0;
               sfwp_pkg::CMD_QUAD_ENTER:    s_d.quad = 1'b1;
               sfwp_pkg::CMD_QUAD_EXIT:     s_d.quad = 1'b0;
               sfwp_pkg::CMD_RESET_ENABLE:  s_d.reset_armed = 1'b1;
               sfwp_pkg::CMD_RESET: begin
                  if (s_q.reset_armed) begin
                     s_d.status[sfwp_pkg::SR_WEL_BIT] = 1'b0;
                     s_d.power_down = 1'b0;
                     s_d.secured    = 1'b0;
                     s_d.quad       = 1'b0;
                  end else begin
                     s_d.reject = 1'b1;
                  end
               end
               sfwp_pkg::CMD_SUSPEND, sfwp_pkg::CMD_RESUME: ;
               sfwp_pkg::CMD_WRITE_STATUS:  k = sfwp_pkg::OP_STATUS;
               sfwp_pkg::CMD_WRITE_SECURITY: k = sfwp_pkg::OP_SECURITY;
               sfwp_pkg::CMD_PAGE_PROG:     k = sfwp_pkg::OP_PROG;
               sfwp_pkg::CMD_SECTOR_ERASE:  k = sfwp_pkg::OP_SECTOR;
               sfwp_pkg::CMD_BLOCK32_ERASE: k = sfwp_pkg::OP_BLK32;
               sfwp_pkg::CMD_BLOCK64_ERASE: k = sfwp_pkg::OP_BLK64;
               sfwp_pkg::CMD_CHIP_ERASE:    k = sfwp_pkg::OP_CHIP;
               default: begin
                  // Lock commands: edge blocks lock by sector.
                  if (!write_enable_latch) begin
                     s_d.reject = 1'b1;
                  end else begin
                     s_d.status[sfwp_pkg::SR_WEL_BIT] = 1'b0;
                     if (s_q.opcode == sfwp_pkg::CMD_GANG_LOCK) begin
                        s_d.blk_lock = '1;
                        s_d.sec_lock = '1;
                     end else if (s_q.opcode == sfwp_pkg::CMD_GANG_UNLOCK) begin
                        s_d.blk_lock = '0;
                        s_d.sec_lock = '0;
                     end else if (a[25:16] == 10'h000 || a[25:16] == 10'h3FF) begin
                        s_d.sec_lock[{a[25], a[15:12]}] = (s_q.opcode == sfwp_pkg::CMD_BLOCK_LOCK);
                     end else begin
                        s_d.blk_lock[a[25:16]] = (s_q.opcode == sfwp_pkg::CMD_BLOCK_LOCK);
                     end
                  end
               end
            endcase
            // Data-changing commands: latch, secured area, protection.
            if (k != sfwp_pkg::OP_NONE) begin
               if (!write_enable_latch) begin
                  s_d.reject = 1'b1;
               end else if (k == sfwp_pkg::OP_STATUS) begin
                  s_d.status[7:2] = s_q.addr[7:2]; // The value byte follows the opcode.
                  if (hw_lock) begin
                     s_d.status[sfwp_pkg::SR_SRWD_BIT] = 1'b1;
                     s_d.status[sfwp_pkg::SR_LEVEL_LSB +: 4] = level;
                  end
               end else if (k == sfwp_pkg::OP_SECURITY) begin
                  s_d.security[sfwp_pkg::SEC_CUST_BIT] = 1'b1;
               end else if (s_q.secured) begin
                  if (k != sfwp_pkg::OP_PROG) begin
                     s_d.reject = 1'b1;
                  end else if (s_q.security[a[sfwp_pkg::OTP_HALF_BIT] ? 0 : 1]) begin
                     s_d.reject = 1'b1;
                  end
               end else if (k == sfwp_pkg::OP_CHIP) begin
                  s_d.reject = (level != 4'h0) || (|s_q.blk_lock) || (|s_q.sec_lock);
               end else if (sfwp_level_hit(a[25:16], level, top_bottom_sel) ||
                            sfwp_lock_hit(a, k, s_q.blk_lock, s_q.sec_lock)) begin
                  s_d.reject = 1'b1;
               end
               if (!s_d.reject) begin
                  s_d.status[sfwp_pkg::SR_WEL_BIT] = 1'b0;
                  s_d.op_start = 1'b1;
                  s_d.op_kind  = k;
                  s_d.op_addr  = a;
                  s_d.op_otp   = s_q.secured & (k == sfwp_pkg::OP_PROG);
               end
            end
         end
      end
   end
   // ==========================================================
   // State register; synchronous reset puts the link in standby.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // Outputs straight from the state record.
   assign status_reg   = s_q.status;
   assign security_reg = s_q.security;
   assign power_down   = s_q.power_down;
   assign secured_mode = s_q.secured;
   assign quad_mode    = s_q.quad;
   assign op_start     = s_q.op_start;
   assign op_kind      = s_q.op_kind;
   assign op_addr      = s_q.op_addr;
   assign op_otp       = s_q.op_otp;
   assign cmd_reject   = s_q.reject;

   // ==========================================================
   // Checks on the command gate.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_latch_gate: assert property (s_q.op_start |-> $past(s_q.status[1]))
      else $error("write cycle started without the write enable latch");
   chk_byte_frame: assert property (s_q.op_start |-> $past(cs_rise) && $past(s_q.bits) == 3'h0)
      else $error("write cycle started from an unframed command");
   chk_latch_clear: assert property (s_q.op_start |-> !s_q.status[1])
      else $error("write enable latch still set after a write cycle start");
   chk_pd_filter: assert property (cs_rise && s_q.power_down && s_q.opcode == sfwp_pkg::CMD_PAGE_PROG
                                   |=> !s_q.op_start)
      else $error("program accepted in deep power-down");
   chk_secure_only: assert property (s_q.op_start && s_q.op_otp |-> s_q.op_kind == sfwp_pkg::OP_PROG)
      else $error("erase reached the array in secured mode");
   chk_otp_lock: assert property (s_q.op_start && s_q.op_otp
                                  |-> !s_q.security[s_q.op_addr[9] ? 0 : 1])
      else $error("locked secured-area half was programmed");
   chk_level_prot: assert property (s_q.op_start && !s_q.op_otp && s_q.op_kind == sfwp_pkg::OP_PROG
                                    |-> !sfwp_level_hit(s_q.op_addr[25:16], $past(level),
                                                        $past(top_bottom_sel)))
      else $error("program started in a level-protected block");
   chk_pin_hold: assert property (cs_rise && s_q.opcode == sfwp_pkg::CMD_WRITE_STATUS &&
                                  s_q.status[7] && !s_q.wp_sy[1] && !s_q.quad && !s_q.status[6]
                                  |=> $stable(level) ##1 $stable(level))
      else $error("protect level changed under pin protection");
   chk_cust_sticky: assert property (s_q.security[1] |=> s_q.security[1])
      else $error("customer lock bit was cleared");

   cov_otp_prog: cover property (s_q.op_start && s_q.op_otp);
   cov_pd_reject: cover property (s_q.reject && s_q.power_down);
   cov_erase64: cover property (s_q.op_start && s_q.op_kind == sfwp_pkg::OP_BLK64);
endmodule // sfwp_top
`default_nettype wire

// ---- tb/sfwp_host.sv ----
// Host controller model that drives the serial link of the protection block.
// Assumes the bench calls send() from one process; sclk runs at 200 ns.
`timescale 1ns/1ps
`default_nettype none
module sfwp_host (
   input  wire logic ref_clk,
   output logic      cs_n,
   output logic      sclk,
   output logic      si
);
   // ==========================================================
   // Idle link: deselected and the clock stands still.
   initial begin
      cs_n = 1'h1;
      sclk = 1'h0;
      si   = 1'h0;
   end
   // Shifts the top nbits of d out MSB first, mode 0, one bit per 8 clocks.
   task automatic send(input logic [47:0] d, input int nbits);
      @(posedge ref_clk);
      cs_n <= 1'h0;
      for (int i = 0; i < nbits; i++) begin
         si <= d[47-i];
         repeat (4) @(posedge ref_clk);
         sclk <= 1'h1;
         repeat (4) @(posedge ref_clk);
         sclk <= 1'h0;
      end
      repeat (4) @(posedge ref_clk);
      cs_n <= 1'h1;
      si   <= ~si; // A released data line must not keep its last value.
   endtask
endmodule // sfwp_host
`default_nettype wire

// ---- tb/test_serial_flash_write_protection.sv ----
// Self-checking bench for the serial flash write-protection block.
// Assumes sfwp_top, sfwp_pkg and the host model sfwp_host.
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_write_protection;
   logic ref_clk, rst, write_protect_pin_io2, factory_lock_strap, top_bottom_sel, cs_n, sclk, si, tbs;
   logic power_down, secured_mode, quad_mode, op_start, op_otp, cmd_reject;
   logic [7:0]  status_reg;
   logic [1:0]  security_reg;
   logic [25:0] op_addr;
   logic [3:0]  lvl;
   logic [9:0]  blk;
   sfwp_pkg::sfwp_op_t op_kind;
   int n_fail, n_checks, seed, cnt;
   sfwp_top DUT (.ref_clk, .rst, .cs_n, .sclk, .si, .write_protect_pin_io2, .factory_lock_strap,
      .top_bottom_sel, .status_reg, .security_reg, .power_down, .secured_mode, .quad_mode,
      .op_start, .op_kind, .op_addr, .op_otp, .cmd_reject);
   sfwp_host host (.ref_clk, .cs_n, .sclk, .si);
   // ==========================================================
   // Clock at 40 MHz.
   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Compares one result and counts it.
   task automatic chk(input string nm, input logic [25:0] exp, input logic [25:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Sends a command and checks whether a write cycle started or it was refused.
   task automatic cmd(input logic [47:0] d, input int nbits, input logic s, input logic r);
      logic st, rj;
      st = 1'h0;
      rj = 1'h0;
      host.send(d, nbits);
      repeat (8) begin
         @(posedge ref_clk);
         #1;
         st = st | op_start;
         rj = rj | cmd_reject;
      end
      chk("op_start", s, st);
      chk("cmd_reject", r, rj);
   endtask
   task automatic op(input logic [7:0] c, input logic s, input logic r);
      cmd({c, 40'h0}, 8, s, r);
   endtask
   task automatic prog(input logic [25:0] a, input logic s);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h0);
      cmd({sfwp_pkg::CMD_PAGE_PROG, 6'h0, a, 8'hA5}, 48, s, ~s);
   endtask
   task automatic wrsr(input logic [7:0] v);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h0);
      cmd({sfwp_pkg::CMD_WRITE_STATUS, v, 32'h0}, 16, 1'h1, 1'h0);
   endtask
   // Expected protection of a 64 KB block from the level and the top/bottom select.
   function automatic logic prot_of(input logic [3:0] l, input logic t, input logic [9:0] b);
      int n;
      n = (l == 4'h0) ? 0 : (l > 4'hA) ? 1024 : (1 << (l - 1));
      return t ? (int'(b) < n) : (int'(b) >= 1024 - n);
   endfunction
   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog sized well beyond the expected run of about 16000 cycles.
   initial begin
      #(25 * 60000);
      n_fail++;
      close_out();
   end
   // ==========================================================
   // Main sequence.
   initial begin
      seed = 46;
      rst = 1'h1;
      write_protect_pin_io2 = 1'h1;
      factory_lock_strap = 1'h1;
      top_bottom_sel = 1'h0;
      repeat (20) @(posedge ref_clk);
      chk("idle", 15'h0, {status_reg, security_reg, power_down, secured_mode, quad_mode, op_start, cmd_reject});
      rst <= 1'h0;
      repeat (8) @(posedge ref_clk);
      chk("factory lock", 1'h1, security_reg[0]);
      cmd({sfwp_pkg::CMD_PAGE_PROG, 40'h0}, 48, 1'h0, 1'h1);
      cmd({sfwp_pkg::CMD_WRITE_ENABLE, 40'h0}, 7, 1'h0, 1'h1);
      chk("latch", 1'h0, status_reg[1]);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h0);
      chk("latch", 1'h1, status_reg[1]);
      cmd({sfwp_pkg::CMD_PAGE_PROG, 40'h0}, 44, 1'h0, 1'h1);
      prog(26'h1234567, 1'h1);
      chk("op_kind", sfwp_pkg::OP_PROG, op_kind);
      chk("op_addr", 26'h1234567, op_addr);
      chk("latch", 1'h0, status_reg[1]);
      for (int i = 0; i < 16; i++) begin
         lvl = (i < 8) ? 4'(i * 2 + (i & 1)) : 4'($random(seed));
         tbs = 1'($random(seed));
         cnt = (lvl == 4'h0) ? 0 : (lvl > 4'hA) ? 1024 : (1 << (lvl - 1));
         blk = (i[0] == 1'h0) ? (tbs ? 10'(cnt) : 10'(1023 - cnt)) : 10'($random(seed));
         @(posedge ref_clk);
         top_bottom_sel <= tbs;
         wrsr({2'h0, lvl, 2'h0});
         chk("level", lvl, status_reg[5:2]);
         prog({blk, 16'(ffs(i))}, ~prot_of(lvl, tbs, blk));
      end
      @(posedge ref_clk);
      top_bottom_sel <= 1'h0;
      wrsr(8'h8C);
      @(posedge ref_clk);
      write_protect_pin_io2 <= 1'h0;
      wrsr(8'h80);
      chk("pin frozen level", 4'h3, status_reg[5:2]);
      op(sfwp_pkg::CMD_QUAD_ENTER, 1'h0, 1'h0);
      chk("quad", 1'h1, quad_mode);
      wrsr(8'h00);
      chk("quad level", 4'h0, status_reg[5:2]);
      op(sfwp_pkg::CMD_QUAD_EXIT, 1'h0, 1'h0);
      write_protect_pin_io2 <= 1'h1;
      op(sfwp_pkg::CMD_POWER_DOWN, 1'h0, 1'h0);
      chk("power_down", 1'h1, power_down);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h1);
      op(sfwp_pkg::CMD_RELEASE_PD, 1'h0, 1'h0);
      chk("power_down", 1'h0, power_down);
      op(sfwp_pkg::CMD_POWER_DOWN, 1'h0, 1'h0);
      op(sfwp_pkg::CMD_SUSPEND, 1'h0, 1'h0);
      op(sfwp_pkg::CMD_RESUME, 1'h0, 1'h0);
      op(sfwp_pkg::CMD_RESET_ENABLE, 1'h0, 1'h0);
      op(sfwp_pkg::CMD_RESET, 1'h0, 1'h0);
      chk("power_down", 1'h0, power_down);
      op(sfwp_pkg::CMD_ENTER_SECURE, 1'h0, 1'h0);
      chk("secured", 1'h1, secured_mode);
      prog(26'h0000010, 1'h1);
      chk("op_otp", 1'h1, op_otp);
      prog(26'h0000210, 1'h0);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h0);
      op(sfwp_pkg::CMD_WRITE_SECURITY, 1'h1, 1'h0);
      chk("customer lock", 1'h1, security_reg[1]);
      prog(26'h00001F0, 1'h0);
      op(sfwp_pkg::CMD_WRITE_ENABLE, 1'h0, 1'h0);
      cmd({sfwp_pkg::CMD_SECTOR_ERASE, 40'h0}, 40, 1'h0, 1'h1);
      op(sfwp_pkg::CMD_EXIT_SECURE, 1'h0, 1'h0);
      chk("secured", 1'h0, secured_mode);
      close_out();
   end
   // Offset spread across a block so addresses vary between trials.
   function automatic int ffs(input int i);
      return (i * 16'h1111) & 16'hFFF0;
   endfunction
endmodule // test_serial_flash_write_protection
`default_nettype wire
